// >>> src/adc_ctrl_map.svh
// Register map, field positions, reset values and timing for the converter control
// Functional notes
// - Completion flag sets regardless of interrupt enable
// - Enabled interrupt raised when completion flag sets
// - Wait and async stop keep converting, interrupting
// - Single conversion ends in low power automatically
// - Stop without async clock aborts, low power
// - After such stop, control write restarts
// - Abort leaves results of last completion intact
// - Async clock enabled: normal operation during stop
// - External mode idles until trigger, converts once
// - External trigger input tied inactive here
// - Break with clear enable: clears stick
// - Break without clear enable: status untouched
// - Two-step clear held across break, finishes after
// - Result rounded to 8 or 10 bits
// - Control write or low read clears flag, request
// - Control write aborts and restarts unless channel ones; external mode arms for trigger instead
// - Channel all ones powers off, isolates, no start
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define ADDR_W 4
`define OFS_STATUS_CONTROL 4'h0
`define OFS_RESULT_HIGH 4'h4
`define OFS_RESULT_LOW 4'h8
`define OFS_CONV_CONFIG 4'hC

`define SC_FLAG_BIT 7
`define SC_IRQ_EN_BIT 6
`define SC_CONT_BIT 5
`define SC_CHAN_MSB 4
`define CFG_ASYNC_BIT 0
`define CFG_TEN_BIT 1
`define CFG_EXT_BIT 2

`define CHAN_OFF 5'h1F
`define CHAN_RESET 5'h1F
`define RESULT_RESET 10'h000
`define RESULT_MAX10 10'h3FF
`define RESULT_MAX8 8'hFF

`define CLK_PERIOD_NS 100
`define SAMPLE_TIME_NS 400
`define SAMPLE_CYCLES ((`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYCLES 3
`define RAW_MSB_IDX 4'hA
`define LAST_IDX_TEN 4'h0
`define LAST_IDX_EIGHT 4'h2

`endif

// >>> src/adc_ctrl_pkg.sv
// Types shared by the converter control and its approximation engine
package adc_ctrl_pkg;

  typedef enum logic [2:0] {
    CTRL_IDLE = 3'b001,
    CTRL_CONV = 3'b010,
    CTRL_WAIT_TRIG = 3'b100
  } ctrl_state_type;

  typedef enum logic [2:0] {
    SAR_IDLE = 3'b001,
    SAR_SAMPLE = 3'b010,
    SAR_TRIAL = 3'b100
  } sar_state_type;

  typedef struct packed {
    sar_state_type state;
    logic [3:0] count;
    logic [3:0] bit_idx;
    logic [10:0] code;
    logic [9:0] result;
    logic done;
    logic sample_on;
  } sar_regs_type;

  typedef struct packed {
    ctrl_state_type state;
    logic waitreq;
    logic [31:0] readdata;
    logic irq_en;
    logic cont;
    logic [4:0] chan;
    logic async_en;
    logic ten_bit;
    logic ext_mode;
    logic flag;
    logic irq;
    logic [9:0] result;
    logic hi_lock;
    logic halted;
    logic comp_meta;
    logic comp_sync;
    logic trig_prev;
    logic active;
    logic isolate;
  } ctrl_regs_type;

endpackage

// >>> src/sar_engine.sv
// Successive approximation sequencer with half-step rounding
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module sar_engine (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic abort,
  input wire logic ten_bit,
  input wire logic comp_high,
  output logic [10:0] trial_code,
  output logic sample_on,
  output logic done,
  output logic [9:0] result
);
  adc_ctrl_pkg::sar_regs_type s_reg;
  adc_ctrl_pkg::sar_regs_type s_next;

  always_comb begin
    logic [10:0] code_v;
    logic [10:0] sum10;
    logic [8:0] sum8;
    code_v = s_reg.code;
    sum10 = 11'h000;
    sum8 = 9'h000;
    s_next = s_reg;
    s_next.done = 1'b0;
    if (abort) begin
      s_next.state = adc_ctrl_pkg::SAR_IDLE;
      s_next.code = 11'h000;
      s_next.sample_on = 1'b0;
    end else if (start) begin
      s_next.state = adc_ctrl_pkg::SAR_SAMPLE;
      s_next.count = 4'h0;
      s_next.code = 11'h000;
      s_next.sample_on = 1'b1;
    end else begin
      case (s_reg.state)
        adc_ctrl_pkg::SAR_SAMPLE: begin
          if (s_reg.count == 4'(`SAMPLE_CYCLES - 1)) begin
            s_next.state = adc_ctrl_pkg::SAR_TRIAL;
            s_next.sample_on = 1'b0;
            s_next.count = 4'h0;
            s_next.bit_idx = `RAW_MSB_IDX;
            s_next.code = 11'h400;
          end else begin
            s_next.count = s_reg.count + 4'h1;
          end
        end
        adc_ctrl_pkg::SAR_TRIAL: begin
          // Dwell covers DAC settling plus the comparator synchroniser
          if (s_reg.count != 4'(`SETTLE_CYCLES - 1)) begin
            s_next.count = s_reg.count + 4'h1;
          end else begin
            s_next.count = 4'h0;
            if (!comp_high) begin
              code_v[s_reg.bit_idx] = 1'b0;
            end
            s_next.code = code_v;
            if (s_reg.bit_idx == (ten_bit ? `LAST_IDX_TEN : `LAST_IDX_EIGHT)) begin
              // One extra raw bit lets the code round to nearest
              sum10 = {1'b0, code_v[10:1]} + {10'h000, code_v[0]};
              sum8 = {1'b0, code_v[10:3]} + {8'h00, code_v[2]};
              if (ten_bit) begin
                s_next.result = sum10[10] ? `RESULT_MAX10 : sum10[9:0];
              end else begin
                s_next.result = {2'b00, sum8[8] ? `RESULT_MAX8 : sum8[7:0]};
              end
              s_next.done = 1'b1;
              // DAC back to zero once the result is latched, so idle draws nothing
              s_next.code = 11'h000;
              s_next.state = adc_ctrl_pkg::SAR_IDLE;
            end else begin
              s_next.bit_idx = s_reg.bit_idx - 4'h1;
              s_next.code[s_reg.bit_idx - 4'h1] = 1'b1;
            end
          end
        end
        default: begin
          s_next.state = adc_ctrl_pkg::SAR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '{state: adc_ctrl_pkg::SAR_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign trial_code = s_reg.code;
  assign sample_on = s_reg.sample_on;
  assign done = s_reg.done;
  assign result = s_reg.result;
endmodule // sar_engine
`default_nettype wire

// >>> src/adc_irq_lowpower_ctrl.sv
// Converter control: status, results, interrupt, low-power and break behaviour
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_irq_lowpower_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`ADDR_W-1:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire logic stop_mode,
  input wire logic break_active,
  input wire logic break_clear_enable,
  input wire logic comparator_in,
  output logic conv_irq,
  output logic [10:0] dac_code,
  output logic sample_on,
  output logic converter_active,
  output logic analog_isolate,
  output logic [4:0] channel_select_field
);
  adc_ctrl_pkg::ctrl_regs_type st_reg;
  adc_ctrl_pkg::ctrl_regs_type st_next;

  logic sar_start;
  logic sar_abort;
  logic sar_done;
  logic [9:0] sar_result;
  logic [10:0] sar_code;
  logic sar_sample;

  // No trigger source on this variant; kept as a constant net
  logic external_conv_trigger;
  assign external_conv_trigger = 1'b0;

  sar_engine u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(sar_start),
    .abort(sar_abort),
    .ten_bit(st_reg.ten_bit),
    .comp_high(st_reg.comp_sync),
    .trial_code(sar_code),
    .sample_on(sar_sample),
    .done(sar_done),
    .result(sar_result)
  );

  always_comb begin
    logic req;
    logic take;
    logic protect;
    logic wr_sc;
    logic wr_cfg;
    logic rd_low;
    logic rd_high;
    logic stop_abort;
    logic trig_rise;
    logic [31:0] rdata;
    req = avm_read | avm_write;
    take = req & ~st_reg.waitreq;
    protect = break_active & ~break_clear_enable;
    wr_sc = take & avm_write & (avm_address == `OFS_STATUS_CONTROL);
    wr_cfg = take & avm_write & (avm_address == `OFS_CONV_CONFIG);
    rd_low = take & avm_read & (avm_address == `OFS_RESULT_LOW);
    rd_high = take & avm_read & (avm_address == `OFS_RESULT_HIGH);
    stop_abort = stop_mode & ~st_reg.async_en;
    trig_rise = external_conv_trigger & ~st_reg.trig_prev;
    rdata = 32'h0000_0000;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    st_next = st_reg;

    // Comparator arrives from the analog side: two flops before use
    st_next.comp_meta = comparator_in;
    st_next.comp_sync = st_reg.comp_meta;
    st_next.trig_prev = external_conv_trigger;

    // One wait cycle per access; effects land on the accepting edge
    st_next.waitreq = ~(req & st_reg.waitreq);
    if (req && st_reg.waitreq && avm_read) begin
      if (avm_address == `OFS_STATUS_CONTROL) begin
        rdata[`SC_FLAG_BIT] = st_reg.flag;
        rdata[`SC_IRQ_EN_BIT] = st_reg.irq_en;
        rdata[`SC_CONT_BIT] = st_reg.cont;
        rdata[`SC_CHAN_MSB:0] = st_reg.chan;
      end else if (avm_address == `OFS_RESULT_HIGH) begin
        rdata[1:0] = st_reg.ten_bit ? st_reg.result[9:8] : 2'b00;
      end else if (avm_address == `OFS_RESULT_LOW) begin
        rdata[7:0] = st_reg.result[7:0];
      end else if (avm_address == `OFS_CONV_CONFIG) begin
        rdata[`CFG_ASYNC_BIT] = st_reg.async_en;
        rdata[`CFG_TEN_BIT] = st_reg.ten_bit;
        rdata[`CFG_EXT_BIT] = st_reg.ext_mode;
      end else begin
        rdata = 32'h0000_0000;
      end
      st_next.readdata = rdata;
    end

    // Clearing actions, suppressed while status is protected in break
    if ((wr_sc || rd_low) && !protect) begin
      st_next.flag = 1'b0;
      st_next.irq = 1'b0;
    end
    // Low read is the second step of the high/low pair
    if (rd_low && !protect) begin
      st_next.hi_lock = 1'b0;
    end
    if (rd_high && st_reg.ten_bit && !protect) begin
      st_next.hi_lock = 1'b1;
    end

    // Completion; set beats any clear in the same cycle
    if (sar_done && st_reg.state == adc_ctrl_pkg::CTRL_CONV) begin
      if (st_reg.hi_lock && st_reg.ten_bit) begin
        // Result discarded while the pair is half read; retry regardless of mode
        sar_start = 1'b1;
      end else begin
        st_next.result = sar_result;
        st_next.flag = 1'b1;
        if (st_reg.irq_en) begin
          st_next.irq = 1'b1;
        end
        if (st_reg.cont && !st_reg.halted) begin
          if (st_reg.ext_mode) begin
            st_next.state = adc_ctrl_pkg::CTRL_WAIT_TRIG;
          end else begin
            sar_start = 1'b1;
          end
        end else begin
          st_next.state = adc_ctrl_pkg::CTRL_IDLE;
        end
      end
    end

    case (st_reg.state)
      adc_ctrl_pkg::CTRL_WAIT_TRIG: begin
        if (trig_rise) begin
          sar_start = 1'b1;
          st_next.state = adc_ctrl_pkg::CTRL_CONV;
        end
      end
      adc_ctrl_pkg::CTRL_CONV: begin
      end
      adc_ctrl_pkg::CTRL_IDLE: begin
      end
      default: begin
        st_next.state = adc_ctrl_pkg::CTRL_IDLE;
      end
    endcase

    if (wr_cfg) begin
      st_next.async_en = avm_writedata[`CFG_ASYNC_BIT];
      st_next.ten_bit = avm_writedata[`CFG_TEN_BIT];
      st_next.ext_mode = avm_writedata[`CFG_EXT_BIT];
    end

    // Control write aborts whatever runs and restarts; external mode arms for trigger, channel off idles
    if (wr_sc) begin
      st_next.irq_en = avm_writedata[`SC_IRQ_EN_BIT];
      st_next.cont = avm_writedata[`SC_CONT_BIT];
      st_next.chan = avm_writedata[`SC_CHAN_MSB:0];
      st_next.halted = 1'b0;
      sar_abort = 1'b1;
      sar_start = 1'b0;
      if (avm_writedata[`SC_CHAN_MSB:0] == `CHAN_OFF) begin
        st_next.state = adc_ctrl_pkg::CTRL_IDLE;
      end else if (st_next.ext_mode) begin
        st_next.state = adc_ctrl_pkg::CTRL_WAIT_TRIG;
      end else begin
        sar_abort = 1'b0;
        sar_start = 1'b1;
        st_next.state = adc_ctrl_pkg::CTRL_CONV;
      end
    end else if (sar_start) begin
      st_next.state = adc_ctrl_pkg::CTRL_CONV;
    end

    // Stop without the async clock wins over everything; results kept
    if (stop_abort) begin
      st_next.halted = 1'b1;
      st_next.state = adc_ctrl_pkg::CTRL_IDLE;
      sar_abort = 1'b1;
      sar_start = 1'b0;
    end

    // Armed for a trigger is still low power; only a running conversion powers up
    st_next.active = (st_next.state == adc_ctrl_pkg::CTRL_CONV);
    st_next.isolate = (st_next.chan == `CHAN_OFF);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '{
        state: adc_ctrl_pkg::CTRL_IDLE,
        waitreq: 1'b1,
        chan: `CHAN_RESET,
        result: `RESULT_RESET,
        isolate: 1'b1,
        default: '0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign avm_readdata = st_reg.readdata;
  assign avm_waitrequest = st_reg.waitreq;
  assign conv_irq = st_reg.irq;
  assign dac_code = sar_code;
  assign sample_on = sar_sample;
  assign converter_active = st_reg.active;
  assign analog_isolate = st_reg.isolate;
  assign channel_select_field = st_reg.chan;
endmodule // adc_irq_lowpower_ctrl
`default_nettype wire

// >>> test/adc_ctrl_monitor.sv
// Port-level checks for the converter control
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_readdata,
  input wire logic avm_waitrequest,
  input wire logic break_active,
  input wire logic break_clear_enable,
  input wire logic conv_irq,
  input wire logic [10:0] dac_code,
  input wire logic converter_active,
  input wire logic analog_isolate,
  input wire logic [4:0] channel_select_field
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic acc;
  logic prot;
  // Idle converter only: a completion in the same cycle would win
  assign acc = !avm_waitrequest && !converter_active;
  assign prot = break_active && !break_clear_enable;
  AST_WAIT_ONE: assert property (!avm_waitrequest |=> avm_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ANSWER: assert property ((avm_read || avm_write) |-> ##[0:2] !avm_waitrequest)
    else $error("bus request not answered");
  AST_UNMAPPED: assert property (
    avm_read && !avm_waitrequest && avm_address[1:0] != 2'h0 |-> avm_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_SC_CLR: assert property (
    avm_write && acc && avm_address == 4'h0 && !prot |=> !conv_irq)
    else $error("control write left request set");
  AST_LOW_CLR: assert property (
    avm_read && acc && avm_address == 4'h8 && !prot |=> !conv_irq)
    else $error("low result read left request set");
  AST_PROTECT: assert property (prot && conv_irq |=> conv_irq)
    else $error("request cleared in protected break");
  AST_IRQ_LEVEL: assert property (conv_irq && !avm_read && !avm_write |=> conv_irq)
    else $error("request dropped without clearing access");
  AST_ISOLATE: assert property (analog_isolate == (channel_select_field == 5'h1F))
    else $error("isolation not tied to channel off");
  AST_OFF_STAYS: assert property (
    channel_select_field == 5'h1F && !converter_active && !avm_write |=> !converter_active)
    else $error("converter woke with channel off");
  AST_IDLE_DAC: assert property (!converter_active && !$past(converter_active) |-> dac_code == 11'h0)
    else $error("trial code driven while idle");
  AST_IRQ_CAUSE: assert property ($rose(conv_irq) |-> $past(converter_active))
    else $error("request without conversion");
  cover property (conv_irq);
  cover property (prot && conv_irq);
  cover property (avm_read && acc && avm_address == 4'h8);
endmodule // adc_ctrl_monitor
bind adc_irq_lowpower_ctrl adc_ctrl_monitor u_mon (.*);
`default_nettype wire

// >>> test/tb_adc_irq_lowpower_ctrl.sv
// Self-checking bench for the converter control
`timescale 1ns/1ps
`default_nettype none
module tb_adc_irq_lowpower_ctrl;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avm_address = 4'h0;
  logic avm_read = 1'b0;
  logic avm_write = 1'b0;
  logic [31:0] avm_writedata = 32'h0;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  logic stop_mode = 1'b0;
  logic break_active = 1'b0;
  logic break_clear_enable = 1'b0;
  logic comparator_in = 1'b0;
  logic conv_irq, sample_on, converter_active, analog_isolate;
  logic [10:0] dac_code;
  logic [4:0] channel_select_field;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] q, last;
  adc_irq_lowpower_ctrl DUT (.*);
  initial forever #50 clk = ~clk;
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avm_address <= a;
    avm_write <= w;
    avm_read <= !w;
    avm_writedata <= d;
    do @(posedge clk); while (avm_waitrequest !== 1'b0);
    q = avm_readdata;
    avm_read <= 1'b0;
    avm_write <= 1'b0;
    // Let the accepting edge's side effects land before anyone samples
    @(negedge clk);
  endtask
  task automatic idle();
    repeat (2) @(posedge clk);
    while (converter_active !== 1'b0) @(posedge clk);
  endtask
  // Comparator held steady: all-ones saturates to full scale, zeros give code 0
  task automatic conv(input logic ten, input logic ie, input logic c);
    logic [31:0] r;
    r = c ? (ten ? 32'h3FF : 32'hFF) : 32'h0;
    @(posedge clk);
    comparator_in <= c;
    bus(1'b1, 4'hC, {30'h0, ten, 1'b0});
    bus(1'b1, 4'h0, {25'h0, ie, 1'b0, 5'($urandom_range(30))});
    idle();
    bus(1'b0, 4'h0, 32'h0);
    chk(q[7], 1);
    chk(conv_irq, ie);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, r >> 8);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, r & 32'hFF);
    chk(conv_irq, 0);
    last = r;
  endtask
  initial begin
    void'($urandom(32'h17AC));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h1F);
    chk(analog_isolate, 1);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 8; i++) conv(i[0], i[1], 1'($urandom_range(1)));
    @(posedge clk);
    comparator_in <= 1'b0;
    bus(1'b1, 4'h0, 32'h23);
    repeat (10) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (3) @(negedge clk);
    chk(converter_active, 0);
    @(posedge clk);
    stop_mode <= 1'b0;
    repeat (60) @(negedge clk);
    chk(converter_active, 0);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, last & 32'hFF);
    bus(1'b1, 4'h0, 32'h03);
    chk(converter_active, 1);
    chk(sample_on, 1);
    idle();
    bus(1'b1, 4'hC, 32'h3);
    @(posedge clk);
    stop_mode <= 1'b1;
    bus(1'b1, 4'h0, 32'h45);
    idle();
    bus(1'b0, 4'h0, 32'h0);
    chk(q[7], 1);
    chk(conv_irq, 1);
    bus(1'b0, 4'h4, 32'h0);
    @(posedge clk);
    break_active <= 1'b1;
    bus(1'b0, 4'h8, 32'h0);
    chk(conv_irq, 1);
    @(posedge clk);
    break_active <= 1'b0;
    bus(1'b0, 4'h8, 32'h0);
    chk(conv_irq, 0);
    bus(1'b1, 4'h0, 32'h45);
    idle();
    break_active <= 1'b1;
    break_clear_enable <= 1'b1;
    bus(1'b0, 4'h8, 32'h0);
    @(posedge clk);
    break_active <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    chk(q[7], 0);
    @(posedge clk);
    stop_mode <= 1'b0;
    bus(1'b1, 4'hC, 32'h4);
    bus(1'b1, 4'h0, 32'h02);
    chk(converter_active, 0);
    repeat (60) @(negedge clk);
    chk(converter_active, 0);
    bus(1'b0, 4'h0, 32'h0);
    chk(q[7], 0);
    bus(1'b1, 4'hC, 32'h0);
    bus(1'b1, 4'h0, 32'h3F);
    repeat (60) @(negedge clk);
    chk(converter_active, 0);
    chk(analog_isolate, 1);
    close_out();
  end
endmodule // tb_adc_irq_lowpower_ctrl
`default_nettype wire
